//--- src/utx_channel.sv
// serial transmit channel with AXI4-Lite registers, status flags and start/stop triggers

module utx_channel (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address channel
   input  wire logic [31:0] awaddr,
   input  wire logic [2:0]  awprot,
   input  wire logic        awvalid,
   output logic             awready,
   // axi4-lite write data channel
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   // axi4-lite write response channel
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   // axi4-lite read address channel
   input  wire logic [31:0] araddr,
   input  wire logic [2:0]  arprot,
   input  wire logic        arvalid,
   output logic             arready,
   // axi4-lite read data channel
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   // serial line
   output logic             txd
);

   // bus slave state
   logic                          aw_got_ff;      // write address held
   logic                          w_got_ff;       // write data held
   logic [utx_pkg::ADDR_W-1:0]    waddr_ff;       // held write address
   logic [31:0]                   wdata_ff;       // held write data
   logic                          wlane0_ff;      // byte lane 0 enabled
   logic                          bvalid_ff;      // write response pending
   logic [1:0]                    bresp_ff;       // write response code
   logic                          rvalid_ff;      // read data pending
   logic [31:0]                   rdata_ff;       // read data
   logic [1:0]                    rresp_ff;       // read response code
   logic                          awready_ff;     // write address may be taken
   logic                          wready_ff;      // write data may be taken
   logic                          arready_ff;     // read address may be taken
   logic                          wstrb_hi_ff;    // byte lane 1 enabled
   logic                          wr_go;          // register write this cycle
   logic                          wr_hit;         // write address mapped
   logic                          ar_take;        // read address taken this cycle
   logic [utx_pkg::ADDR_W-1:0]    raddr;          // read address low bits

   // channel state
   logic                          se_ff;          // channel_enabled_status
   logic                          bff_ff;         // tx_buffer_valid_flag
   logic                          tsf_ff;         // comm_in_progress_flag
   logic [7:0]                    tbuf_ff;        // transmit_buffer
   logic [7:0]                    shift_ff;       // shift register
   logic [2:0]                    bitcnt_ff;      // data bit index
   logic [15:0]                   bauddiv_ff;     // clocks per bit
   logic [15:0]                   baudcnt_ff;     // baud divider count
   logic                          tick;           // one-cycle bit-time enable
   logic                          txd_ff;         // serial output
   utx_pkg::utx_state_type        state_ff;       // sequencer state
   utx_pkg::utx_state_type        nxt_state;      // next sequencer state
   logic                          load;           // buffer moves to shifter
   logic                          start_wr;       // start trigger written with one
   logic                          stop_wr;        // stop trigger written with one
   logic                          txdata_wr;      // transmit_data written
   utx_pkg::utx_status_type       status;         // status byte

   // outputs straight from flip-flops
   assign awready = awready_ff;
   assign wready  = wready_ff;
   assign bvalid  = bvalid_ff;
   assign bresp   = bresp_ff;
   assign arready = arready_ff;
   assign rvalid  = rvalid_ff;
   assign rdata   = rdata_ff;
   assign rresp   = rresp_ff;
   assign txd     = txd_ff;

   // write decode: performed once both halves are held
   assign wr_go     = aw_got_ff & w_got_ff & ~bvalid_ff;
   assign wr_hit    = (waddr_ff == utx_pkg::ADDR_STATUS) | (waddr_ff == utx_pkg::ADDR_START)
                    | (waddr_ff == utx_pkg::ADDR_STOP) | (waddr_ff == utx_pkg::ADDR_TXDATA)
                    | (waddr_ff == utx_pkg::ADDR_BAUDDIV) | (waddr_ff == utx_pkg::ADDR_ENABLED);
   assign start_wr  = wr_go & wlane0_ff & (waddr_ff == utx_pkg::ADDR_START)
                    & wdata_ff[utx_pkg::BIT_TRIGGER];
   assign stop_wr   = wr_go & wlane0_ff & (waddr_ff == utx_pkg::ADDR_STOP)
                    & wdata_ff[utx_pkg::BIT_TRIGGER];
   assign txdata_wr = wr_go & wlane0_ff & (waddr_ff == utx_pkg::ADDR_TXDATA);
   assign ar_take   = arvalid & arready_ff;
   assign raddr     = araddr[utx_pkg::ADDR_W-1:0];

   // ready flags hold next cycle's free-to-accept condition, so a taken half,
   // a pending response or reset keeps each one low without a combinational path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         arready_ff <= 1'b0;
      end else begin
         awready_ff <= ~(awvalid & awready_ff) & ~aw_got_ff & ~(bvalid_ff & ~bready);
         wready_ff  <= ~(wvalid & wready_ff) & ~w_got_ff & ~(bvalid_ff & ~bready);
         arready_ff <= ~(arvalid & arready_ff) & ~(rvalid_ff & ~rready);
      end
   end

   // write address capture, released when the register write happens
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff <= 1'b0;
         waddr_ff  <= '0;
      end else if (awvalid && awready) begin
         aw_got_ff <= 1'b1;
         waddr_ff  <= {awaddr[utx_pkg::ADDR_W-1:2], 2'b00};
      end else if (wr_go) begin
         aw_got_ff <= 1'b0;
      end
   end

   // write data capture, independent of address order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_got_ff  <= 1'b0;
         wdata_ff  <= '0;
         wlane0_ff <= 1'b0;
      end else if (wvalid && wready) begin
         w_got_ff  <= 1'b1;
         wdata_ff  <= wdata;
         wlane0_ff <= wstrb[0];
      end else if (wr_go) begin
         w_got_ff <= 1'b0;
      end
   end

   // write response: slverr for unmapped offsets
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= utx_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= wr_hit ? utx_pkg::RESP_OKAY : utx_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // status byte assembly; error flags stay zero on a transmit-only channel
   always_comb begin
      status       = '0;
      status.tsf   = tsf_ff;
      status.bff   = bff_ff;
      status.pef   = 1'b0;
      status.ovf   = 1'b0;
   end

   // read channel: data one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= '0;
         rresp_ff  <= utx_pkg::RESP_OKAY;
      end else if (ar_take) begin
         rvalid_ff <= 1'b1;
         rresp_ff  <= utx_pkg::RESP_OKAY;
         rdata_ff  <= '0;
         case ({raddr[utx_pkg::ADDR_W-1:2], 2'b00})
            utx_pkg::ADDR_STATUS:  rdata_ff <= {24'h000000, status};
            utx_pkg::ADDR_BAUDDIV: rdata_ff <= {16'h0000, bauddiv_ff};
            utx_pkg::ADDR_ENABLED: rdata_ff <= {31'h00000000, se_ff};
            // trigger and data registers are write only and read zero
            utx_pkg::ADDR_START, utx_pkg::ADDR_STOP, utx_pkg::ADDR_TXDATA: rdata_ff <= '0;
            default: rresp_ff <= utx_pkg::RESP_SLVERR;
         endcase
      end else if (rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   // baud divisor register, low 16 bits through lanes 0 and 1
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bauddiv_ff <= utx_pkg::BAUDDIV_RST;
      end else if (wr_go && waddr_ff == utx_pkg::ADDR_BAUDDIV) begin
         if (wlane0_ff) begin
            bauddiv_ff[7:0] <= wdata_ff[7:0];
         end
         if (wstrb_hi_ff) begin
            bauddiv_ff[15:8] <= wdata_ff[15:8];
         end
      end
   end

   // byte lane 1 enable, kept beside the data for the divisor
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wstrb_hi_ff <= 1'b0;
      end else if (wvalid && wready) begin
         wstrb_hi_ff <= wstrb[1];
      end
   end

   // channel enable: start sets it, stop clears it; stop wins if both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         se_ff <= 1'b0;
      end else if (stop_wr) begin
         se_ff <= 1'b0;
      end else if (start_wr) begin
         se_ff <= 1'b1;
      end
   end

   // bit-time divider, restarted at each frame start so the start bit is whole
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         baudcnt_ff <= '0;
      end else if (state_ff == utx_pkg::TX_IDLE || tick) begin
         baudcnt_ff <= '0;
      end else begin
         baudcnt_ff <= baudcnt_ff + 16'h0001;
      end
   end
   // a divisor of zero or one ticks every clock instead of wrapping the compare
   assign tick = (state_ff != utx_pkg::TX_IDLE)
               && ((bauddiv_ff <= 16'h0001) || (baudcnt_ff >= bauddiv_ff - 16'h0001));

   // buffer to shifter transfer once enabled and the shifter is free: from idle, or at
   // the end of a stop bit so that a waiting byte follows without a gap
   assign load = se_ff & bff_ff & ~stop_wr
               & ((state_ff == utx_pkg::TX_IDLE) | ((state_ff == utx_pkg::TX_STOP) & tick));

   // transmit buffer: a new write sets the flag even in the cycle it is emptied
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bff_ff  <= 1'b0;
         tbuf_ff <= utx_pkg::TXDATA_RST;
      end else if (txdata_wr) begin
         bff_ff  <= 1'b1;
         tbuf_ff <= wdata_ff[7:0];
      end else if (load || stop_wr) begin
         bff_ff <= 1'b0;
      end
   end

   // sequencer next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         utx_pkg::TX_IDLE:  if (load) nxt_state = utx_pkg::TX_START;
         utx_pkg::TX_START: if (tick) nxt_state = utx_pkg::TX_DATA;
         utx_pkg::TX_DATA: begin
            if (tick && bitcnt_ff == utx_pkg::LAST_DATA_BIT) begin
               nxt_state = utx_pkg::TX_STOP;
            end
         end
         utx_pkg::TX_STOP: begin
            if (tick) begin
               nxt_state = load ? utx_pkg::TX_START : utx_pkg::TX_IDLE;
            end
         end
         default: nxt_state = utx_pkg::TX_IDLE;
      endcase
      if (stop_wr) begin
         nxt_state = utx_pkg::TX_IDLE;
      end
   end

   // sequencer state, bit counter and shift register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff  <= utx_pkg::TX_IDLE;
         bitcnt_ff <= '0;
         shift_ff  <= '0;
      end else begin
         state_ff <= nxt_state;
         if (load) begin
            shift_ff  <= tbuf_ff;
            bitcnt_ff <= '0;
         end else if (tick && state_ff == utx_pkg::TX_DATA) begin
            shift_ff  <= {1'b0, shift_ff[7:1]};
            bitcnt_ff <= bitcnt_ff + 3'h1;
         end
      end
   end

   // serial line: idle high, start low, data lsb first, stop high
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         txd_ff <= 1'b1;
      end else begin
         case (nxt_state)
            utx_pkg::TX_START: txd_ff <= 1'b0;
            utx_pkg::TX_DATA:  txd_ff <= (state_ff == utx_pkg::TX_DATA && tick)
                                         ? shift_ff[1] : shift_ff[0];
            default:           txd_ff <= 1'b1;
         endcase
      end
   end

   // communication in progress from buffer load until the stop bit ends
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tsf_ff <= 1'b0;
      end else begin
         tsf_ff <= (nxt_state != utx_pkg::TX_IDLE);
      end
   end

endmodule : utx_channel

//--- src/utx_pkg.sv
// package for the serial transmit channel: register map, fields, timing and types
package utx_pkg;
   // register byte addresses on the AXI4-Lite bus
   localparam logic [7:0] ADDR_STATUS   = 8'h00;  // channel_status, read only
   localparam logic [7:0] ADDR_START    = 8'h04;  // channel_start_trigger_reg, write only
   localparam logic [7:0] ADDR_STOP     = 8'h08;  // channel_stop_trigger_reg, write only
   localparam logic [7:0] ADDR_TXDATA   = 8'h0c;  // transmit_data, write only
   localparam logic [7:0] ADDR_BAUDDIV  = 8'h10;  // baud divisor, read/write
   localparam logic [7:0] ADDR_ENABLED  = 8'h14;  // channel_enabled_status, read only
   localparam int         ADDR_W        = 8;      // decoded address width

   // field positions
   localparam int BIT_TSF     = 6;  // comm_in_progress_flag
   localparam int BIT_BFF     = 5;  // tx_buffer_valid_flag
   localparam int BIT_PEF     = 1;  // parity_error_flag, never set by a transmitter
   localparam int BIT_OVF     = 0;  // overrun_error_flag, never set by a transmitter
   localparam int BIT_TRIGGER = 0;  // trigger bit of start and stop registers
   localparam int BIT_SE      = 0;  // enabled bit of the enabled register

   // reset values
   localparam logic [15:0] BAUDDIV_RST = 16'h043d;  // 125 MHz / 1085 = about 115200 baud
   localparam logic [7:0]  TXDATA_RST  = 8'h00;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // frame shape: one start bit, eight data bits lsb first, one stop bit
   localparam logic [2:0] LAST_DATA_BIT = 3'h7;

   // transmitter sequencer states
   typedef enum logic [1:0] {
      TX_IDLE,
      TX_START,
      TX_DATA,
      TX_STOP
   } utx_state_type;

   // status byte as software sees it
   typedef struct packed {
      logic       zero7;  // reads zero
      logic       tsf;    // comm_in_progress_flag
      logic       bff;    // tx_buffer_valid_flag
      logic [2:0] zero4;  // reads zero
      logic       pef;    // parity_error_flag
      logic       ovf;    // overrun_error_flag
   } utx_status_type;
endpackage : utx_pkg

//--- testbench/utx_rx_model.sv
// behavioural host receiver that decodes frames from the transmit line
module utx_rx_model #(
   parameter int DIV = 4  // clocks per bit
) (
   // clock and line
   input wire logic aclk,
   input wire logic txd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] q [$];  // bytes received in order
   logic [7:0] sh;     // byte being assembled
   // start edge, mid-bit sampling lsb first, keep the byte only if the stop bit is high
   always begin
      @(negedge txd);
      repeat (DIV / 2) @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
         repeat (DIV) @(posedge aclk);
         sh[i] = txd;
      end
      repeat (DIV) @(posedge aclk);
      if (txd) q.push_back(sh);
   end
endmodule : utx_rx_model

//--- testbench/utx_channel_props.sv
// bus and serial line assertions for the transmit channel
module utx_channel_props (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // write side
   input wire logic [31:0] awaddr,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic [31:0] wdata,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   // read side
   input wire logic [31:0] araddr,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic        rvalid,
   // serial line
   input wire logic        txd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic rd_stat_ff;  // read in flight targets status
   logic rd_busy_ff;  // line was low, so inside a frame, when that read was taken
   logic wr_bad_ff;   // write in flight targets no register
   // remember what the read in flight addressed
   always_ff @(posedge aclk) begin
      if (arvalid && arready) begin
         rd_stat_ff <= (araddr[7:0] == utx_pkg::ADDR_STATUS);
         rd_busy_ff <= !txd;
      end
   end
   // remember whether the write in flight is unmapped
   always_ff @(posedge aclk) begin
      if (awvalid && awready) begin
         wr_bad_ff <= ((awaddr[7:0] & 8'hfc) > utx_pkg::ADDR_ENABLED);
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // both write halves taken at one edge
   sequence s_wr_hs;
      awvalid && awready && wvalid && wready;
   endsequence
   // stop trigger written with its bit set
   sequence s_stop;
      s_wr_hs ##0 (awaddr[7:0] == utx_pkg::ADDR_STOP && wdata[0]);
   endsequence
   AST_WR_LAT: assert property (s_wr_hs |-> ##[1:2] bvalid)
      else $error("write got no response");
   AST_RD_LAT: assert property (arvalid && arready |=> rvalid)
      else $error("read got no data");
   AST_AW_BLOCK: assert property (bvalid |-> !awready && !wready)
      else $error("write accepted with response pending");
   AST_AR_BLOCK: assert property (rvalid |-> !arready)
      else $error("read accepted with data pending");
   AST_RESP: assert property (bvalid |-> bresp == (wr_bad_ff ? 2'b10 : 2'b00))
      else $error("wrong write response");
   AST_STAT_RSVD: assert property (rvalid && rd_stat_ff |-> rdata[31:7] == 0 && rdata[4:0] == 0)
      else $error("status unused bits set");
   AST_BUSY_FLAG: assert property (rvalid && rd_stat_ff && rd_busy_ff |-> rdata[6])
      else $error("busy flag low inside a frame");
   AST_STOP_IDLE: assert property (s_stop |-> ##[1:3] (txd [*8]))
      else $error("line not idle after stop");
endmodule : utx_channel_props
bind utx_channel utx_channel_props u_props (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
   .awvalid(awvalid), .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready),
   .bresp(bresp), .bvalid(bvalid), .araddr(araddr), .arvalid(arvalid), .arready(arready),
   .rdata(rdata), .rvalid(rvalid), .txd(txd));

//--- testbench/tb.sv
// self-checking bench for the serial transmit channel
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // one bus operation and what it should give
   typedef struct packed {
      logic        wr;   // write when set
      logic [7:0]  adr;  // byte address
      logic [31:0] dat;  // write data or expected read data
      logic [1:0]  rsp;  // expected response
   } utx_row_type;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, txd;
   logic [31:0] awaddr, wdata, araddr, rdata, rdv;
   logic [1:0]  bresp, rresp, rs;
   int          mismatches, checks;
   utx_row_type rows [13] = '{'{0, 8'h10, 32'h43d, 0}, '{0, 8'h00, 0, 0},
      '{1, 8'h10, 4, 0}, '{0, 8'h10, 4, 0}, '{1, 8'h04, 1, 0}, '{0, 8'h14, 1, 0},
      '{0, 8'h04, 0, 0}, '{1, 8'h08, 0, 0}, '{0, 8'h14, 1, 0}, '{1, 8'h08, 1, 0},
      '{0, 8'h14, 0, 0}, '{1, 8'h18, 5, 2}, '{0, 8'h18, 0, 2}};
   // device and host receiver
   utx_channel u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .txd(txd));
   utx_rx_model #(.DIV(4)) u_rx (.aclk(aclk), .txd(txd));
   // clock, 8 ns period
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // compare one value and count it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // bus write, both halves offered together, each held until taken
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w;
      @(posedge aclk);
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw = 1'b0;
      w = 1'b0;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (awvalid && awready) aw = 1'b1;
         if (wvalid && wready) w = 1'b1;
         awvalid <= !aw;
         wvalid <= !w;
      end
      do @(posedge aclk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : bus_wr
   // bus read
   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : bus_rd
   // poll status until the masked bits match
   task automatic poll(input logic [31:0] m, input logic [31:0] v);
      int n;
      n = 0;
      do begin
         bus_rd(utx_pkg::ADDR_STATUS, rdv, rs);
         n++;
      end while ((rdv & m) !== v && n < 200);
      chk(rdv & m, v);
   endtask : poll
   // print the counts and the verdict
   task automatic results();
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results
   // watchdog
   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      results();
   end
   // main sequence
   initial begin
      mismatches = 0;
      checks = 0;
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, wdata, araddr} = '0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      // register table rows
      foreach (rows[i]) begin
         if (rows[i].wr) bus_wr(rows[i].adr, rows[i].dat, rs);
         else bus_rd(rows[i].adr, rdv, rs);
         if (!rows[i].wr) chk(rdv, rows[i].dat);
         chk(32'(rs), 32'(rows[i].rsp));
      end
      // byte held while disabled, then sent after start with a refill mid-frame
      bus_wr(utx_pkg::ADDR_TXDATA, 32'ha5, rs);
      bus_rd(utx_pkg::ADDR_STATUS, rdv, rs);
      chk(rdv, 32'h20);
      bus_wr(utx_pkg::ADDR_START, 32'h1, rs);
      poll(32'h20, 32'h0);
      bus_wr(utx_pkg::ADDR_TXDATA, 32'h3c, rs);
      bus_rd(utx_pkg::ADDR_STATUS, rdv, rs);
      chk(rdv, 32'h60);
      poll(32'h60, 32'h0);
      chk(32'(u_rx.q.size()), 32'h2);
      chk(32'(u_rx.q[0]), 32'ha5);
      chk(32'(u_rx.q[1]), 32'h3c);
      // stop in mid-frame with a byte waiting
      bus_wr(utx_pkg::ADDR_TXDATA, 32'h81, rs);
      poll(32'h40, 32'h40);
      bus_wr(utx_pkg::ADDR_TXDATA, 32'h7e, rs);
      bus_wr(utx_pkg::ADDR_STOP, 32'h1, rs);
      bus_rd(utx_pkg::ADDR_STATUS, rdv, rs);
      chk(rdv, 32'h0);
      chk(32'(txd), 32'h1);
      bus_rd(utx_pkg::ADDR_ENABLED, rdv, rs);
      chk(rdv, 32'h0);
      // reset in mid-frame: outputs idle during it, registers back to reset values after
      bus_wr(utx_pkg::ADDR_START, 32'h1, rs);
      bus_wr(utx_pkg::ADDR_TXDATA, 32'h55, rs);
      repeat (10) @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(32'({awready, wready, arready, bvalid, rvalid, txd}), 32'h01);
      aresetn <= 1'b1;
      bus_rd(utx_pkg::ADDR_STATUS, rdv, rs);
      chk(rdv, 32'h0);
      bus_rd(utx_pkg::ADDR_ENABLED, rdv, rs);
      chk(rdv, 32'h0);
      bus_rd(utx_pkg::ADDR_BAUDDIV, rdv, rs);
      chk(rdv, 32'(utx_pkg::BAUDDIV_RST));
      chk(32'(txd), 32'h1);
      results();
   end
endmodule : tb
